// [cps_pkg.sv]
// Purpose: Shared constants for the current and power scaling backend
// Assumes: 50 MHz pclk, APB register access with 32-bit data
// Notes: Conversion times are kept in microseconds, counts derived below
package cps_pkg;

  // Clock rate, used to turn microseconds into pclk cycles
  localparam int unsigned CLK_MHZ = 50;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_SHUNT_CAL = 8'h04;
  localparam logic [7:0] ADDR_SHUNT_RES = 8'h08;
  localparam logic [7:0] ADDR_RAIL_RES = 8'h0C;
  localparam logic [7:0] ADDR_CURRENT = 8'h10;
  localparam logic [7:0] ADDR_POWER = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Configuration field positions
  localparam int unsigned CFG_RANGE_BIT = 0;
  localparam int unsigned CFG_CONV_LSB = 1;
  localparam int unsigned CFG_AVG_LSB = 4;
  localparam int unsigned SEL_W = 3;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [15:0] CAL_RESET = 16'h0000;

  // Conversion times in microseconds, selected by the conversion field
  localparam int unsigned CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam int unsigned TIMER_W = 18;

  // Averaging counts 1,4,16,64,128,256,512,1024 as shift amounts
  localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int unsigned CNT_W = 11;
  localparam int unsigned ACC_W = 26;

  // Arithmetic scaling: current = shunt * 4096 / cal, power = |cur| * rail / 64
  localparam int unsigned CUR_SHIFT = 12;
  localparam int unsigned PWR_SHIFT = 6;
  localparam int unsigned DIV_W = 29;
  localparam logic [15:0] CUR_POS_MAX = 16'h7FFF;
  localparam logic [15:0] CUR_NEG_MIN = 16'h8000;
  localparam logic [23:0] PWR_MAX = 24'hFFFFFF;

  // Result sequencer states
  typedef enum logic [2:0] {
    CPS_IDLE = 3'b001,
    CPS_DIVIDE = 3'b010,
    CPS_POWER = 3'b100
  } cps_state_t;

endpackage

// [cps_divider.sv]
// Purpose: Sequential unsigned restoring divider for the current scaling
// Assumes: Divisor nonzero; caller handles the zero case and the signs
// Notes: One quotient bit per clock, done pulses once after DIV_W cycles
`timescale 1ns/100ps
module cps_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [cps_pkg::DIV_W-1:0] dividend,
  input wire logic [15:0] divisor,
  output logic done,
  output logic [cps_pkg::DIV_W-1:0] quotient
);

  logic [16:0] rem;
  logic [15:0] dvs;
  logic [5:0] cnt;
  logic busy;
  logic [16:0] shifted;
  logic [17:0] diff;

  // Trial subtraction of the divisor from the shifted remainder
  always_comb begin
    shifted = {rem[15:0], quotient[cps_pkg::DIV_W-1]};
    diff = {1'b0, shifted} - {2'b00, dvs};
  end

  // Iteration control and done pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= 6'(cps_pkg::DIV_W);
        busy <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // Remainder and quotient shift register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem <= 17'h00000;
      dvs <= 16'h0000;
      quotient <= '0;
    end else if (start) begin
      rem <= 17'h00000;
      dvs <= divisor;
      quotient <= dividend;
    end else if (busy) begin
      rem <= diff[17] ? shifted : diff[16:0]; // Restore on borrow
      quotient <= {quotient[cps_pkg::DIV_W-2:0], ~diff[17]};
    end
  end

endmodule // cps_divider

// [cps_top.sv]
// Purpose: Current and power scaling backend of a shunt power monitor
// Assumes: Converter codes arrive on pclk, valid when a conversion ends
// Notes: APB slave with zero wait states; unmapped addresses answer pslverr
`timescale 1ns/100ps
module cps_top #(
  parameter int unsigned CONV_CYCLES [8] = '{
    cps_pkg::CONV_US[0] * cps_pkg::CLK_MHZ, cps_pkg::CONV_US[1] * cps_pkg::CLK_MHZ,
    cps_pkg::CONV_US[2] * cps_pkg::CLK_MHZ, cps_pkg::CONV_US[3] * cps_pkg::CLK_MHZ,
    cps_pkg::CONV_US[4] * cps_pkg::CLK_MHZ, cps_pkg::CONV_US[5] * cps_pkg::CLK_MHZ,
    cps_pkg::CONV_US[6] * cps_pkg::CLK_MHZ, cps_pkg::CONV_US[7] * cps_pkg::CLK_MHZ}
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] adc_shunt_code,
  input wire logic [15:0] adc_rail_code,
  output logic conv_start,
  output logic input_range_select
);

  logic [6:0] config_reg;
  logic [15:0] shunt_cal;
  logic [15:0] shunt_voltage_result;
  logic [15:0] supply_rail_voltage_result;
  logic [15:0] current_result;
  logic [23:0] power_result;
  logic [15:0] update_count;
  logic [cps_pkg::TIMER_W-1:0] conv_timer;
  logic [cps_pkg::CNT_W-1:0] sample_cnt;
  logic signed [cps_pkg::ACC_W-1:0] shunt_acc;
  logic [cps_pkg::ACC_W-1:0] rail_acc;
  logic mean_ready;
  logic signed [15:0] mean_shunt;
  logic [15:0] mean_rail;
  cps_pkg::cps_state_t state;
  logic div_start;
  logic div_done;
  logic [cps_pkg::DIV_W-1:0] div_dividend;
  logic [cps_pkg::DIV_W-1:0] div_quotient;
  logic [15:0] div_divisor;
  logic cur_negative;
  logic [15:0] cur_calc;
  logic [15:0] cur_mag;
  logic [31:0] pwr_product;
  logic [25:0] pwr_scaled;
  logic apb_write;
  logic addr_ok;
  logic cfg_write;
  logic [2:0] conv_sel;
  logic [2:0] avg_sel;
  logic conv_end;
  logic [cps_pkg::CNT_W-1:0] avg_count;
  logic signed [cps_pkg::ACC_W-1:0] next_shunt_acc;
  logic [cps_pkg::ACC_W-1:0] next_rail_acc;
  logic signed [cps_pkg::ACC_W-1:0] shunt_shifted;
  logic [cps_pkg::ACC_W-1:0] rail_shifted;
  logic [16:0] shunt_mag;

  // Address decode behind the error answer
  // Reads of unmapped words return zero; writes there are dropped
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == cps_pkg::ADDR_CONFIG) || (a == cps_pkg::ADDR_SHUNT_CAL) ||
                  (a == cps_pkg::ADDR_SHUNT_RES) || (a == cps_pkg::ADDR_RAIL_RES) ||
                  (a == cps_pkg::ADDR_CURRENT) || (a == cps_pkg::ADDR_POWER) ||
                  (a == cps_pkg::ADDR_STATUS);
  endfunction

  // Access-phase qualifiers; the slave never inserts wait states
  always_comb begin
    apb_write = psel && penable && pwrite;
    addr_ok = addr_mapped(paddr);
    cfg_write = apb_write && (paddr == cps_pkg::ADDR_CONFIG);
    conv_sel = config_reg[cps_pkg::CFG_CONV_LSB +: cps_pkg::SEL_W];
    avg_sel = config_reg[cps_pkg::CFG_AVG_LSB +: cps_pkg::SEL_W];
    avg_count = cps_pkg::CNT_W'(1) << cps_pkg::AVG_SHIFT[avg_sel];
  end

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= cps_pkg::CFG_RESET;
      shunt_cal <= cps_pkg::CAL_RESET;
    end else if (apb_write) begin
      if (paddr == cps_pkg::ADDR_CONFIG) begin
        config_reg <= pwdata[6:0];
      end else if (paddr == cps_pkg::ADDR_SHUNT_CAL) begin
        shunt_cal <= pwdata[15:0];
      end
    end
  end

  // Read data and response, registered so every bus output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable; // Ready in the access phase
      pslverr <= psel && !penable && !addr_ok;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        if (paddr == cps_pkg::ADDR_CONFIG) begin
          prdata <= {25'h0000000, config_reg};
        end else if (paddr == cps_pkg::ADDR_SHUNT_CAL) begin
          prdata <= {16'h0000, shunt_cal};
        end else if (paddr == cps_pkg::ADDR_SHUNT_RES) begin
          prdata <= {16'h0000, shunt_voltage_result};
        end else if (paddr == cps_pkg::ADDR_RAIL_RES) begin
          prdata <= {16'h0000, supply_rail_voltage_result};
        end else if (paddr == cps_pkg::ADDR_CURRENT) begin
          prdata <= {16'h0000, current_result};
        end else if (paddr == cps_pkg::ADDR_POWER) begin
          prdata <= {8'h00, power_result};
        end else if (paddr == cps_pkg::ADDR_STATUS) begin
          prdata <= {15'h0000, state != cps_pkg::CPS_IDLE, update_count};
        end
      end
    end
  end

  // Range select drives the front end; the scaling stays 4096/cal in both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_range_select <= 1'b0;
    end else begin
      input_range_select <= config_reg[cps_pkg::CFG_RANGE_BIT];
    end
  end

  // Conversion timer; a configuration write restarts the period
  // A restart while a start pulse stands reuses that pulse, so starts stay single
  always_comb begin
    conv_end = (conv_timer == cps_pkg::TIMER_W'(CONV_CYCLES[conv_sel] - 1));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_timer <= '0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (cfg_write || conv_end) begin
        conv_timer <= '0;
        conv_start <= !conv_start; // One pulse even when a restart meets a start
      end else begin
        conv_timer <= conv_timer + cps_pkg::TIMER_W'(1);
      end
    end
  end

  // Accumulate conversion codes over the averaging period
  always_comb begin
    next_shunt_acc = shunt_acc + cps_pkg::ACC_W'(signed'(adc_shunt_code));
    next_rail_acc = rail_acc + cps_pkg::ACC_W'(adc_rail_code);
    shunt_shifted = next_shunt_acc >>> cps_pkg::AVG_SHIFT[avg_sel];
    rail_shifted = next_rail_acc >> cps_pkg::AVG_SHIFT[avg_sel];
  end

  // Mean taken once per averaging period; a count of one passes codes through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shunt_acc <= '0;
      rail_acc <= '0;
      sample_cnt <= '0;
      mean_ready <= 1'b0;
      mean_shunt <= 16'sh0000;
      mean_rail <= 16'h0000;
    end else begin
      mean_ready <= 1'b0;
      if (cfg_write) begin
        shunt_acc <= '0; // Partial period dropped on a setting change
        rail_acc <= '0;
        sample_cnt <= '0;
      end else if (conv_end) begin
        if (sample_cnt == avg_count - cps_pkg::CNT_W'(1)) begin
          shunt_acc <= '0;
          rail_acc <= '0;
          sample_cnt <= '0;
          mean_shunt <= shunt_shifted[15:0];
          mean_rail <= rail_shifted[15:0];
          mean_ready <= 1'b1;
        end else begin
          shunt_acc <= next_shunt_acc;
          rail_acc <= next_rail_acc;
          sample_cnt <= sample_cnt + cps_pkg::CNT_W'(1);
        end
      end
    end
  end

  // Divider feed: magnitude of the shunt code scaled by 4096
  always_comb begin
    shunt_mag = mean_shunt[15] ? 17'(-{mean_shunt[15], mean_shunt}) : {1'b0, mean_shunt};
    div_dividend = cps_pkg::DIV_W'(shunt_mag) << cps_pkg::CUR_SHIFT;
  end

  cps_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start),
    .dividend(div_dividend),
    .divisor(div_divisor),
    .done(div_done),
    .quotient(div_quotient)
  );

  // Signed current from the quotient, clamped to 16 bits
  always_comb begin
    if (cur_negative) begin
      if (div_quotient >= cps_pkg::DIV_W'(cps_pkg::CUR_NEG_MIN)) begin
        cur_calc = cps_pkg::CUR_NEG_MIN;
      end else begin
        cur_calc = 16'(-div_quotient[15:0]);
      end
    end else if (div_quotient > cps_pkg::DIV_W'(cps_pkg::CUR_POS_MAX)) begin
      cur_calc = cps_pkg::CUR_POS_MAX;
    end else begin
      cur_calc = div_quotient[15:0];
    end
    cur_mag = current_result[15] ? 16'(-current_result) : current_result;
    pwr_product = cur_mag * supply_rail_voltage_result;
    pwr_scaled = pwr_product[31:cps_pkg::PWR_SHIFT];
  end

  // Result sequencer: latch results, divide, then form power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cps_pkg::CPS_IDLE;
      div_start <= 1'b0;
      div_divisor <= 16'h0000;
      cur_negative <= 1'b0;
      shunt_voltage_result <= 16'h0000;
      supply_rail_voltage_result <= 16'h0000;
      current_result <= 16'h0000;
      power_result <= 24'h000000;
      update_count <= 16'h0000;
    end else begin
      div_start <= 1'b0;
      case (state)
        cps_pkg::CPS_IDLE: begin
          if (mean_ready) begin
            shunt_voltage_result <= mean_shunt;
            supply_rail_voltage_result <= mean_rail;
            cur_negative <= mean_shunt[15];
            div_divisor <= shunt_cal;
            if (shunt_cal == cps_pkg::CAL_RESET) begin
              current_result <= 16'h0000;
              state <= cps_pkg::CPS_POWER;
            end else begin
              div_start <= 1'b1;
              state <= cps_pkg::CPS_DIVIDE;
            end
          end
        end
        cps_pkg::CPS_DIVIDE: begin
          if (div_done) begin
            current_result <= cur_calc;
            state <= cps_pkg::CPS_POWER;
          end
        end
        cps_pkg::CPS_POWER: begin
          if (pwr_scaled > 26'(cps_pkg::PWR_MAX)) begin
            power_result <= cps_pkg::PWR_MAX;
          end else begin
            power_result <= pwr_scaled[23:0];
          end
          update_count <= update_count + 16'h0001;
          state <= cps_pkg::CPS_IDLE;
        end
        default: begin
          state <= cps_pkg::CPS_IDLE;
        end
      endcase
    end
  end

endmodule // cps_top

// [cps_monitor.sv]
// Purpose: Port-level checker for the scaling backend
// Assumes: Zero-wait APB slave, one clock domain
// Notes: Helpers follow calibration and period writes seen on the bus
`timescale 1ns/100ps
module cps_monitor #(
  parameter int unsigned CONV_CYCLES [8] = '{60, 70, 80, 90, 100, 110, 120, 130}
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] adc_shunt_code,
  input wire logic [15:0] adc_rail_code,
  input wire logic conv_start,
  input wire logic input_range_select
);
  logic [2:0] sel;
  logic cfgw;
  logic seen;
  logic calz;
  logic [4:0] zcnt;
  logic [17:0] gcnt;
  wire cfg_wr = psel && penable && pwrite && paddr == cps_pkg::ADDR_CONFIG;
  wire cal_wr = psel && penable && pwrite && paddr == cps_pkg::ADDR_SHUNT_CAL;
  wire rd_ok = pready && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Gap between starts; a config write restarts the timer, so that gap is skipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel <= 3'h0;
      cfgw <= 1'b0;
      seen <= 1'b0;
      gcnt <= 18'h00000;
    end else begin
      gcnt <= conv_start ? 18'h00000 : gcnt + 18'h00001;
      seen <= seen || conv_start;
      cfgw <= cfg_wr || (cfgw && !conv_start);
      if (cfg_wr) sel <= pwdata[3:1];
    end
  end
  // Conversions since calibration went to zero, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calz <= 1'b1;
      zcnt <= 5'h1F;
    end else if (cal_wr) begin
      calz <= pwdata[15:0] == 16'h0000;
      zcnt <= 5'h00;
    end else if (conv_start && zcnt != 5'h1F) zcnt <= zcnt + 5'h01;
  end
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_unmapped_err: assert property (pready && paddr > cps_pkg::ADDR_STATUS |-> pslverr)
    else $error("unmapped access without error");
  chk_power_width: assert property (rd_ok && paddr == cps_pkg::ADDR_POWER |->
    prdata[31:24] == 8'h00) else $error("power wider than 24 bits");
  chk_current_width: assert property (rd_ok && paddr == cps_pkg::ADDR_CURRENT |->
    prdata[31:16] == 16'h0000) else $error("current upper bits set");
  chk_result_width: assert property (rd_ok && (paddr == cps_pkg::ADDR_SHUNT_RES ||
    paddr == cps_pkg::ADDR_RAIL_RES) |-> prdata[31:16] == 16'h0000)
    else $error("voltage result wider than 16 bits");
  chk_zero_cal: assert property (rd_ok && paddr == cps_pkg::ADDR_CURRENT && calz &&
    zcnt >= 5'h14 |-> prdata == 32'h00000000) else $error("current nonzero");
  chk_conv_gap: assert property (conv_start && seen && !cfgw |->
    gcnt == CONV_CYCLES[sel] - 1) else $error("conversion period wrong");
  chk_range_copy: assert property (cfg_wr |-> ##2
    input_range_select == $past(pwdata[0], 2)) else $error("range select not followed");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  cov_current: cover property (rd_ok && paddr == cps_pkg::ADDR_CURRENT && prdata != 32'h0);
  cov_err: cover property (pready && pslverr);
  cov_narrow: cover property (conv_start && input_range_select);
endmodule // cps_monitor

bind cps_top cps_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_shunt_code(adc_shunt_code),
  .adc_rail_code(adc_rail_code), .conv_start(conv_start),
  .input_range_select(input_range_select));

// [cps_front_model.sv]
// Purpose: Far-side model: converter codes plus host calibration arithmetic
// Assumes: Codes change only at a conversion start
// Notes: Holding codes for a whole conversion hides any sampling slip
`timescale 1ns/100ps
module cps_front_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_start,
  input wire logic [15:0] shunt_set,
  input wire logic [15:0] rail_set,
  output logic [15:0] adc_shunt_code,
  output logic [15:0] adc_rail_code
);
  // New codes for each conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_shunt_code <= 16'h0000;
      adc_rail_code <= 16'h0000;
    end else if (conv_start) begin
      adc_shunt_code <= shunt_set;
      adc_rail_code <= rail_set;
    end
  end
  // Host calibration; a coarser step scales the constant up
  function automatic logic [15:0] cal_for(real imax, real rsh, int mult, logic narrow);
    real lsb;
    lsb = imax / 32768.0 * mult;
    cal_for = 16'($rtoi(819.2e6 * lsb * rsh * (narrow ? 4.0 : 1.0) + 0.5));
  endfunction
endmodule // cps_front_model

// [test_current_power_scaling.sv]
// Purpose: Self-checking bench for the scaling backend
// Assumes: Short conversion counts; results settle within 45 cycles
// Notes: Expected values come from the scaling equations only
`timescale 1ns/100ps
module test_current_power_scaling;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_start;
  logic input_range_select;
  logic [15:0] adc_shunt_code;
  logic [15:0] adc_rail_code;
  logic [15:0] shunt_set = 16'h0000;
  logic [15:0] rail_set = 16'h0000;
  int err_count = 0;
  int checked = 0;
  always #10 pclk = ~pclk;
  cps_top #(.CONV_CYCLES('{60, 70, 80, 90, 100, 110, 120, 130})) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_shunt_code(adc_shunt_code), .adc_rail_code(adc_rail_code),
    .conv_start(conv_start), .input_range_select(input_range_select));
  cps_front_model host (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .shunt_set(shunt_set), .rail_set(rail_set), .adc_shunt_code(adc_shunt_code),
    .adc_rail_code(adc_rail_code));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // One APB transfer; waits for ready, the watchdog cuts a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(q, exp, m);
  endtask
  // Let n conversions start, then the result pipeline drain
  task automatic settle(input int n);
    repeat (n) @(posedge pclk iff conv_start === 1'b1);
    repeat (45) @(posedge pclk);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd_chk(cps_pkg::ADDR_CONFIG, 32'h00000000, "config reset");
    rd_chk(cps_pkg::ADDR_SHUNT_CAL, 32'h00000000, "cal reset");
    wr(cps_pkg::ADDR_SHUNT_CAL, 32'h0000ABCD);
    rd_chk(cps_pkg::ADDR_SHUNT_CAL, 32'h0000ABCD, "cal readback");
    apb(1'b0, 8'h40, 32'h00000000, q, e);
    chk({31'h0, e}, 32'h00000001, "unmapped error");
    $display("regs test done");
  endtask
  // Wide, narrow, negative and coarse-step cases
  task automatic t_scale;
    int sh, mag, cur;
    logic [15:0] cal;
    for (int k = 0; k < 4; k++) begin
      sh = (k == 2) ? -1000 : ((k == 1) ? 4000 : 1000);
      cal = host.cal_for(10.0, 0.002, (k == 3) ? 2 : 1, k == 1);
      wr(cps_pkg::ADDR_CONFIG, {31'h0, k == 1});
      wr(cps_pkg::ADDR_SHUNT_CAL, {16'h0000, cal});
      shunt_set <= sh[15:0];
      rail_set <= 16'h03E8;
      settle(3);
      mag = (sh < 0) ? -sh : sh;
      cur = mag * 4096 / cal;
      chk({31'h0, input_range_select}, {31'h0, k == 1}, "range pin");
      rd_chk(cps_pkg::ADDR_SHUNT_RES, {16'h0000, sh[15:0]}, "shunt result");
      rd_chk(cps_pkg::ADDR_RAIL_RES, 32'h000003E8, "rail result");
      rd_chk(cps_pkg::ADDR_CURRENT, {16'h0000, 16'((sh < 0) ? -cur : cur)}, "current");
      rd_chk(cps_pkg::ADDR_POWER, 32'(cur * 1000 / 64), "power");
    end
    $display("scale test done");
  endtask
  task automatic t_zero;
    wr(cps_pkg::ADDR_CONFIG, 32'h00000000);
    wr(cps_pkg::ADDR_SHUNT_CAL, 32'h00000000);
    shunt_set <= 16'h1000;
    settle(20);
    rd_chk(cps_pkg::ADDR_CURRENT, 32'h00000000, "current with zero cal");
    rd_chk(cps_pkg::ADDR_POWER, 32'h00000000, "power with zero cal");
    $display("zero cal test done");
  endtask
  // Every conversion time; averages 1, 4, 16 count updates over 16 conversions
  task automatic t_period;
    logic [31:0] s0, s1;
    logic e;
    logic [2:0] av;
    for (int i = 0; i < 8; i++) begin
      av = (i < 3) ? 3'(i) : 3'h0;
      wr(cps_pkg::ADDR_CONFIG, {25'h0, av, 3'(i), 1'b0});
      settle(2);
      apb(1'b0, cps_pkg::ADDR_STATUS, 32'h00000000, s0, e);
      settle(16);
      apb(1'b0, cps_pkg::ADDR_STATUS, 32'h00000000, s1, e);
      chk({16'h0000, s1[15:0] - s0[15:0]}, 32'd16 >> cps_pkg::AVG_SHIFT[av], "updates");
    end
    $display("period test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_scale;
    t_zero;
    t_period;
    close_out;
  end
  // Watchdog well beyond the expected run of about 16000 cycles
  initial begin
    #(60000 * 20);
    err_count++;
    close_out;
  end
endmodule // test_current_power_scaling
